/* File: inc/nac_consts.svh */
`ifndef NAC_CONSTS_SVH
`define NAC_CONSTS_SVH

// ------------------------------------------------------------------
// Register indices and byte addresses (index times four)
// ------------------------------------------------------------------
`define NAC_IDX_AVG          8'h07
`define NAC_IDX_NODE         8'h0A
`define NAC_IDX_TAG          8'h0B
`define NAC_IDX_CTRL         8'h0C
`define NAC_ADDR_AVG         8'h1C
`define NAC_ADDR_NODE        8'h28
`define NAC_ADDR_TAG         8'h2C
`define NAC_ADDR_CTRL        8'h30
`define NAC_ADDR_CFG         8'h40
`define NAC_ADDR_KEY1        8'h44
`define NAC_ADDR_KEY2        8'h48
`define NAC_ADDR_STAT        8'h4C

// ------------------------------------------------------------------
// Field positions and widths
// ------------------------------------------------------------------
`define NAC_CTRL_RESET       7
`define NAC_CTRL_SHUT        6
`define NAC_CTRL_WAKE        5
`define NAC_CTRL_SAVE        4
`define NAC_CTRL_ASSIGN      3
`define NAC_CFG_ADDR_SRC     0
`define NAC_NODE_W           5
`define NAC_TAG_W            4
`define NAC_AVG_W            3

// ------------------------------------------------------------------
// Values
// ------------------------------------------------------------------
`define NAC_KEY1_VALUE       32'h8C2DB194
`define NAC_KEY2_VALUE       32'hA375E60F
`define NAC_AVG_MAX_CODE     3'h5
`define NAC_AVG_LOG_MAX      3'h5
`define NAC_ZERO8            8'h00
`define NAC_ZERO32           32'h0000_0000
`define NAC_HTRANS_NONSEQ    2'h2
`define NAC_HSIZE_WORD       3'h2
`define NAC_ADDR_LSB         2
`define NAC_RST_CYCLES       4'h8

`endif

/* File: inc/nac_pkg.sv */
package nac_pkg;
   typedef enum logic [2:0] {
      NAC_IDLE = 3'b001,
      NAC_ACC  = 3'b010,
      NAC_OUT  = 3'b100
   } nac_avg_state_t;

   typedef struct packed {
      logic [2:0]     avg_code;
      logic [4:0]     node_number;
      logic [3:0]     tag_low;
      logic           addr_src;
      logic [31:0]    key1;
      logic [31:0]    key2;
      logic           wake_busy;
      logic           save_busy;
      logic           assign_on;
      logic           shut;
      logic [3:0]     rst_cnt;
      logic           dp_wr;
      logic [7:0]     dp_addr;
      logic [31:0]    rdata;
      logic [2:0]     gpio_s1;
      logic [4:0]     gpio_s2;
      logic [4:0]     gpio_s3;
      logic [4:0]     gpio_s4;
      nac_avg_state_t avg_st;
      logic [5:0]     avg_cnt;
      logic [20:0]    avg_sum;
      logic [15:0]    result;
      logic           result_valid;
   } nac_state_t;
endpackage

/* File: src/nac_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nac_consts.svh"

module nac_regs
   import nac_pkg::*;
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Link frame side
   input  wire logic        frame_done,
   input  wire logic [4:0]  req_node,
   input  wire logic        req_group,
   input  wire logic [7:0]  req_tag,
   output logic             addr_match,
   output logic             group_match,
   output logic             upstream_block,
   // Wake tone and nonvolatile memory
   output logic             wake_start,
   input  wire logic        wake_done,
   output logic             save_start,
   input  wire logic        save_done,
   // Pins and device control
   input  wire logic [4:0]  gpio_pins,
   output logic             soft_reset,
   output logic             shutdown_request,
   // Sample averaging
   input  wire logic        sample_valid,
   input  wire logic [15:0] sample_data,
   output logic [15:0]      avg_result,
   output logic             avg_valid
);

   nac_state_t s_reg;
   nac_state_t s_next;

   logic        wr_go;
   logic [7:0]  wd;
   logic [5:0]  avg_target;
   logic [2:0]  shift;
   logic [20:0] rounded;
   logic [20:0] half;
   logic [20:0] frac_mask;
   logic [20:0] frac;
   logic        keys_ok;

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   always_comb begin
      wr_go      = s_reg.dp_wr;
      wd         = hwdata[7:0];
      keys_ok    = (s_reg.key1 == `NAC_KEY1_VALUE) && (s_reg.key2 == `NAC_KEY2_VALUE);
      shift      = (s_reg.avg_code > `NAC_AVG_MAX_CODE) ? `NAC_AVG_LOG_MAX : s_reg.avg_code;
      avg_target = 6'(1) << shift;
      half       = (shift == 3'h0) ? 21'h0 : (21'(1) << (shift - 3'h1));
      frac_mask  = (21'(1) << shift) - 21'h1;
      frac       = s_reg.avg_sum & frac_mask;
      // Round half to even: round up above half, or at half when quotient is odd
      rounded    = s_reg.avg_sum >> shift;
      if ((frac > half) || ((shift != 3'h0) && (frac == half) && rounded[0])) begin
         rounded = rounded + 21'h1;
      end
   end

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      s_next              = s_reg;
      s_next.result_valid = 1'b0;
      s_next.gpio_s1      = {s_reg.gpio_s1[1:0], 1'b0};

      // Pin synchroniser
      s_next.gpio_s2 = gpio_pins;
      s_next.gpio_s3 = s_reg.gpio_s2;
      s_next.gpio_s4 = s_reg.gpio_s3;

      // Address phase capture
      s_next.dp_wr   = hsel && hready && (htrans == `NAC_HTRANS_NONSEQ) && hwrite;
      s_next.dp_addr = haddr;
      s_next.rdata   = `NAC_ZERO32;
      if (hsel && hready && (htrans == `NAC_HTRANS_NONSEQ) && !hwrite) begin
         case (haddr)
            `NAC_ADDR_AVG:  s_next.rdata = {29'h0, s_reg.avg_code};
            `NAC_ADDR_NODE: s_next.rdata = {27'h0, s_reg.node_number};
            `NAC_ADDR_TAG:  s_next.rdata = {28'h0, s_reg.tag_low};
            `NAC_ADDR_CTRL: s_next.rdata = {26'h0, s_reg.wake_busy, s_reg.save_busy,
                                            s_reg.assign_on && s_reg.addr_src, 3'h0};
            `NAC_ADDR_CFG:  s_next.rdata = {31'h0, s_reg.addr_src};
            `NAC_ADDR_KEY1: s_next.rdata = s_reg.key1;
            `NAC_ADDR_KEY2: s_next.rdata = s_reg.key2;
            `NAC_ADDR_STAT: s_next.rdata = {31'h0, s_reg.shut};
            default:        s_next.rdata = `NAC_ZERO32;
         endcase
      end

      // Completion events: done clears busy unless a new start lands
      if (wake_done) begin
         s_next.wake_busy = 1'b0;
      end
      if (save_done) begin
         s_next.save_busy = 1'b0;
      end
      if (frame_done && s_reg.addr_src) begin
         s_next.assign_on = 1'b0;
      end

      // Soft reset hold counter
      if (s_reg.rst_cnt != 4'h0) begin
         s_next.rst_cnt = s_reg.rst_cnt - 4'h1;
      end

      // Data phase write
      if (wr_go) begin
         case (s_reg.dp_addr)
            `NAC_ADDR_AVG: s_next.avg_code = wd[`NAC_AVG_W-1:0];
            `NAC_ADDR_NODE: begin
               if (s_reg.assign_on && s_reg.addr_src) begin
                  s_next.node_number = wd[`NAC_NODE_W-1:0];
               end
            end
            `NAC_ADDR_TAG: s_next.tag_low = wd[`NAC_TAG_W-1:0];
            `NAC_ADDR_CTRL: begin
               if (wd[`NAC_CTRL_RESET]) begin
                  s_next.rst_cnt = `NAC_RST_CYCLES;
               end
               if (wd[`NAC_CTRL_SHUT]) begin
                  s_next.shut = 1'b1;
               end
               if (wd[`NAC_CTRL_WAKE]) begin
                  s_next.wake_busy = 1'b1;
               end
               if (wd[`NAC_CTRL_SAVE] && keys_ok && !s_reg.save_busy) begin
                  s_next.save_busy = 1'b1;
               end
               if (wd[`NAC_CTRL_ASSIGN]) begin
                  if (s_reg.addr_src) begin
                     s_next.assign_on = 1'b1;
                  end else begin
                     s_next.gpio_s1[0] = 1'b1;
                  end
               end
            end
            // Changing the source leaves the node number untouched
            `NAC_ADDR_CFG:  s_next.addr_src = wd[`NAC_CFG_ADDR_SRC];
            `NAC_ADDR_KEY1: s_next.key1 = hwdata;
            `NAC_ADDR_KEY2: s_next.key2 = hwdata;
            default: ;
         endcase
      end

      // Pin sample: take gpio_s3 once synchroniser stages agree, or one cycle later regardless
      if (s_reg.gpio_s1[2] || (s_reg.gpio_s1[1] && (s_reg.gpio_s3 == s_reg.gpio_s4))) begin
         s_next.node_number = s_reg.gpio_s3;
         s_next.gpio_s1     = 3'h0;
      end

      // Averaging engine
      case (s_reg.avg_st)
         NAC_IDLE: begin
            if (sample_valid) begin
               s_next.avg_sum = {5'h0, sample_data};
               s_next.avg_cnt = 6'h1;
               s_next.avg_st  = (avg_target == 6'h1) ? NAC_OUT : NAC_ACC;
            end
         end
         NAC_ACC: begin
            if (sample_valid) begin
               s_next.avg_sum = s_reg.avg_sum + {5'h0, sample_data};
               s_next.avg_cnt = s_reg.avg_cnt + 6'h1;
               if (s_reg.avg_cnt + 6'h1 == avg_target) begin
                  s_next.avg_st = NAC_OUT;
               end
            end
         end
         NAC_OUT: begin
            s_next.result       = rounded[15:0];
            s_next.result_valid = 1'b1;
            s_next.avg_st       = NAC_IDLE;
         end
         default: s_next.avg_st = NAC_IDLE;
      endcase

      // Soft reset reinitialises the register state except save_busy, on its last hold cycle
      if (s_reg.rst_cnt == 4'h1) begin
         s_next.avg_code    = 3'h0;
         s_next.node_number = 5'h0;
         s_next.tag_low     = 4'h0;
         s_next.addr_src    = 1'b0;
         s_next.key1        = `NAC_ZERO32;
         s_next.key2        = `NAC_ZERO32;
         s_next.wake_busy   = 1'b0;
         s_next.assign_on   = 1'b0;
         s_next.shut        = 1'b0;
         s_next.avg_st      = NAC_IDLE;
      end
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg        <= '0;
         s_reg.avg_st <= NAC_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   always_comb begin
      hreadyout        = 1'b1;
      hresp            = 1'b0;
      hrdata           = s_reg.rdata;
      addr_match       = (req_node == s_reg.node_number);
      group_match      = req_group && (req_tag == {4'h0, s_reg.tag_low});
      upstream_block   = s_reg.wake_busy;
      wake_start       = wr_go && (s_reg.dp_addr == `NAC_ADDR_CTRL) && wd[`NAC_CTRL_WAKE];
      save_start       = wr_go && (s_reg.dp_addr == `NAC_ADDR_CTRL) && wd[`NAC_CTRL_SAVE]
                         && keys_ok && !s_reg.save_busy;
      soft_reset       = (s_reg.rst_cnt != 4'h0);
      shutdown_request = s_reg.shut;
      avg_result       = s_reg.result;
      avg_valid        = s_reg.result_valid;
   end

endmodule
`default_nettype wire

/* File: test/nac_regs_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module nac_regs_chk (
   // Bus
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   // Control outputs and wake_done
   input wire logic        wake_start,
   input wire logic        wake_done,
   input wire logic        upstream_block,
   input wire logic        save_start,
   input wire logic        soft_reset,
   input wire logic        shutdown_request
);
   logic       wr_q;
   logic       rd_q;
   logic [7:0] a_q;
   logic       tk;
   assign tk = hsel && hreadyout && htrans == 2'h2;
   // Data phase tracking
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         a_q  <= 8'h00;
      end else begin
         wr_q <= tk && hwrite;
         rd_q <= tk && !hwrite;
         a_q  <= haddr;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_rst_hold;
      soft_reset [*8] ##1 !soft_reset;
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or error");
   a_wake_cause: assert property (wake_start |-> wr_q && a_q == 8'h30 && hwdata[5])
      else $error("wake start without write");
   a_wake_block: assert property (wake_start |=> upstream_block)
      else $error("no block after wake");
   a_block_hold: assert property (upstream_block && !wake_done && !soft_reset |=> upstream_block)
      else $error("block dropped early");
   a_save_cause: assert property (save_start |-> wr_q && a_q == 8'h30 && hwdata[4])
      else $error("save start without write");
   a_rst_len: assert property ($rose(soft_reset) |-> s_rst_hold)
      else $error("soft reset length wrong");
   a_rst_cause: assert property ($rose(soft_reset) |-> $past(wr_q) && $past(hwdata[7]))
      else $error("soft reset without write");
   a_shut_cause: assert property ($rose(shutdown_request) |-> $past(wr_q) && $past(hwdata[6]))
      else $error("shutdown without write");
   a_shut_keep: assert property (shutdown_request && !soft_reset && !$past(soft_reset)
      |=> shutdown_request || soft_reset)
      else $error("shutdown dropped");
   a_tag_rsvd: assert property (rd_q && a_q == 8'h2C |-> hrdata[31:4] == 28'h0)
      else $error("tag upper bits set");
   a_node_rsvd: assert property (rd_q && a_q == 8'h28 |-> hrdata[31:5] == 27'h0)
      else $error("node upper bits set");
endmodule
`default_nettype wire

/* File: test/nac_far.sv */
`timescale 1ns/1ps
`default_nettype none
module nac_far (
   // Clock and reset
   input wire logic       hclk,
   input wire logic       hresetn,
   // Response delay and handshakes
   input wire logic [7:0] lat,
   input wire logic       wake_start,
   input wire logic       save_start,
   output logic           wake_done,
   output logic           save_done
);
   int wc;
   int sc;
   // Tone and programming finish after lat cycles
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wc        <= 0;
         sc        <= 0;
         wake_done <= 1'b0;
         save_done <= 1'b0;
      end else begin
         wc        <= wake_start ? int'(lat) : (wc > 0 ? wc - 1 : 0);
         sc        <= save_start ? int'(lat) : (sc > 0 ? sc - 1 : 0);
         wake_done <= wc == 1;
         save_done <= sc == 1;
      end
   end
endmodule
`default_nettype wire

/* File: test/nac_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module nac_regs_tb;
   logic        hclk = 1'b0;
   logic        hresetn, hsel, hwrite, frame_done, req_group, sample_valid;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [4:0]  req_node, gpio_pins;
   logic [7:0]  haddr, req_tag, lat;
   logic [15:0] sample_data, avg_result;
   logic [31:0] hwdata, hrdata, q;
   logic        hreadyout, hresp, addr_match, group_match, upstream_block, wake_start;
   logic        wake_done, save_start, save_done, soft_reset, shutdown_request, avg_valid;
   int          miscompares, cmp_count, node, tag, s, n, k, r, e;
   always #5 hclk = ~hclk;
   nac_regs u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .frame_done, .req_node, .req_group,
      .req_tag, .addr_match, .group_match, .upstream_block, .wake_start, .wake_done,
      .save_start, .save_done, .gpio_pins, .soft_reset, .shutdown_request, .sample_valid,
      .sample_data, .avg_result, .avg_valid);
   nac_far u_far (.hclk, .hresetn, .lat, .wake_start, .save_start, .wake_done, .save_done);
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
      cmp_count++;
      if (seen !== ex) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, ex, seen);
      end
   endtask
   task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] ex);
      xf(1'b0, a, 32'h0);
      chk(nm, q, ex);
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge hclk);
      #1;
   endtask
   task automatic poll(input int b);
      e = 0;
      do begin
         xf(1'b0, 8'h30, 32'h0);
         e++;
      end while ((q & b) != 0 && e < 100);
      if ((q & b) != 0) miscompares++;
   endtask
   task results;
      $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
      if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge hclk);
      miscompares++;
      results;
   end
   initial begin
      {hresetn, hsel, hwrite, frame_done, req_group, sample_valid} = 6'h00;
      {htrans, haddr, hwdata, req_node, gpio_pins, req_tag, sample_data} = 76'h0;
      hsize = 3'h2;
      lat = 8'h28;
      s = $urandom(32'h2B1A831E);
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      rc("ctrl", 8'h30, 32'h0);
      rc("unmapped", 8'h3C, 32'h0);
      tag = $urandom;
      xf(1'b1, 8'h2C, tag);
      rc("tag", 8'h2C, tag & 15);
      req_group <= 1'b1;
      req_tag <= 8'(tag & 15);
      cyc(1);
      chk("group", 32'(group_match), 32'h1);
      req_tag <= 8'(tag | 16);
      cyc(1);
      chk("group", 32'(group_match), 32'h0);
      xf(1'b1, 8'h28, 32'h1F);
      rc("node", 8'h28, 32'h0);
      node = $urandom_range(31, 1);
      gpio_pins <= 5'(node);
      xf(1'b1, 8'h30, 32'h8);
      cyc(6);
      rc("node", 8'h28, node);
      rc("ctrl", 8'h30, 32'h0);
      req_node <= 5'(node);
      cyc(1);
      chk("match", 32'(addr_match), 32'h1);
      xf(1'b1, 8'h40, 32'h1);
      xf(1'b1, 8'h30, 32'h8);
      rc("ctrl", 8'h30, 32'h8);
      node = $urandom;
      xf(1'b1, 8'h28, node);
      rc("node", 8'h28, node & 31);
      frame_done <= 1'b1;
      @(posedge hclk);
      frame_done <= 1'b0;
      rc("ctrl", 8'h30, 32'h0);
      xf(1'b1, 8'h28, ~node);
      xf(1'b1, 8'h40, 32'h0);
      rc("node", 8'h28, node & 31);
      xf(1'b1, 8'h30, 32'h20);
      cyc(1);
      chk("block", 32'(upstream_block), 32'h1);
      rc("ctrl", 8'h30, 32'h20);
      poll(32);
      chk("block", 32'(upstream_block), 32'h0);
      xf(1'b1, 8'h44, 32'h8C2DB194);
      xf(1'b1, 8'h48, 32'h5C8A19F0);
      xf(1'b1, 8'h30, 32'h10);
      rc("ctrl", 8'h30, 32'h0);
      xf(1'b1, 8'h48, 32'hA375E60F);
      xf(1'b1, 8'h30, 32'h10);
      rc("ctrl", 8'h30, 32'h10);
      poll(16);
      chk("save", q, 32'h0);
      for (k = 0; k < 8; k++) begin
         xf(1'b1, 8'h1C, k);
         rc("code", 8'h1C, k);
         n = 1 << (k > 5 ? 5 : k);
         s = 0;
         repeat (n) begin
            @(posedge hclk);
            r = $urandom_range(65535);
            s += r;
            sample_valid <= 1'b1;
            sample_data <= 16'(r);
         end
         @(posedge hclk);
         sample_valid <= 1'b0;
         e = 0;
         while (avg_valid !== 1'b1 && e < 4) begin
            cyc(1);
            e++;
         end
         if (avg_valid !== 1'b1) miscompares++;
         r = s % n;
         s = s / n;
         if (2 * r > n || (2 * r == n && s % 2 == 1)) s++;
         chk("avg", 32'(avg_result), s);
      end
      xf(1'b1, 8'h30, 32'h40);
      rc("ctrl", 8'h30, 32'h0);
      chk("shut", 32'(shutdown_request), 32'h1);
      xf(1'b1, 8'h30, 32'h80);
      rc("ctrl", 8'h30, 32'h0);
      e = 0;
      while (soft_reset === 1'b1 && e < 20) begin
         cyc(1);
         e++;
      end
      if (soft_reset === 1'b1) miscompares++;
      cyc(2);
      chk("shut", 32'(shutdown_request), 32'h0);
      rc("tag", 8'h2C, 32'h0);
      results;
   end
endmodule
bind nac_regs nac_regs_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
   .hreadyout, .hresp, .hrdata, .wake_start, .wake_done, .upstream_block, .save_start,
   .soft_reset, .shutdown_request);
`default_nettype wire
